// ==== logic/nbi_buf2.sv ====
`timescale 1ns/1ps
// Two-entry buffer carrying read bytes to the user
module nbi_buf2 (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Fill side
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [7:0] in_data,
    // Drain side
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic [7:0]      out_data
);
    logic [7:0] mem_q [2];   // Storage
    logic       wp_q;        // Write index
    logic       rp_q;        // Read index
    logic [1:0] cnt_q;       // Fill level
    logic       push;
    logic       pop;

    // Honest full and empty
    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
        end else if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) wp_q <= ~wp_q;
            if (pop)  rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    chk_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_q <= 2'h2) else $error("buffer level above two");
endmodule

// ==== logic/nbi_host.sv ====
`timescale 1ns/1ps
`include "nbi_regs.svh"
// Host-side NAND bus sequencer: one request = one strobed byte
module nbi_host (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // Request port
    input  wire logic           req_valid,
    output logic                req_ready,
    input  wire nbi_pkg::nbi_op_t req_op,
    input  wire logic [7:0]     req_data,
    input  wire logic           wp_allow,
    // Read data port
    output logic                rd_valid,
    input  wire logic           rd_ready,
    output logic [7:0]          rd_data,
    // Status
    output logic                dev_busy,
    // NAND pins
    output logic                chip_sel_n,
    output logic                cmd_latch,
    output logic                addr_latch,
    output logic                write_strobe_n,
    output logic                read_strobe_n,
    output logic                write_prot_n,
    output logic [7:0]          io_o,
    output logic                io_oe,
    input  wire logic [7:0]     io_i,
    input  wire logic           ready_busy_n
);
    nbi_pkg::nbi_state_t st_q;
    nbi_pkg::nbi_op_t    op_q;
    logic [2:0]          cnt_q;     // Phase counter
    logic [7:0]          dout_q;    // Byte driven to device
    logic                cs_q;      // Chip select held active
    logic                cap_valid; // Captured byte handed to buffer
    logic                buf_ready; // Buffer has room for one more byte
    logic [7:0]          cap_data;  // Byte sampled from the bus
    logic [2:0]          acyc_q;    // Address cycles since last command
    logic [7:0]          col_lo_q;  // Low column byte of current address
    logic                byte_done; // Write-type byte latched by device

    // Phase length by state
    function automatic logic [2:0] phase_len(input nbi_pkg::nbi_state_t s);
        unique case (s)
            nbi_pkg::NBI_SETUP:  phase_len = `NBI_SETUP_CYC;
            nbi_pkg::NBI_STROBE: phase_len = `NBI_STROBE_CYC;
            nbi_pkg::NBI_HOLD:   phase_len = `NBI_HOLD_CYC;
            nbi_pkg::NBI_IDLE:   phase_len = 3'h1;
        endcase
    endfunction

    // Command codes the device defines; anything else is a prohibited input
    function automatic logic cmd_known(input logic [7:0] c);
        cmd_known = c inside {8'h00, 8'h05, 8'h06, 8'h10, 8'h11, 8'h15, 8'h30, 8'h31,
                              8'h35, 8'h3F, 8'h60, 8'h70, 8'h78, 8'h80, 8'h81, 8'h85,
                              8'h90, 8'hD0, 8'hD1, 8'hE0, 8'hEC, 8'hED, 8'hEE, 8'hEF,
                              8'hFF};
    endfunction

    // Address cycles two and five leave their upper lines unused
    function automatic logic pad_low(input logic [2:0] n, input logic [7:0] b);
        if (n == 3'h1) begin
            pad_low = (b[7:4] == 4'h0);
        end else if (n == 3'h4) begin
            pad_low = (b[7:1] == 7'h00);
        end else begin
            pad_low = 1'b1;
        end
    endfunction

    // Read cycles stall while the buffer is full so no byte is lost
    assign req_ready = (st_q == nbi_pkg::NBI_IDLE)
                       && !(req_op == nbi_pkg::NBI_OP_RD && !buf_ready);
    assign dev_busy  = !ready_busy_n; // (pull-up outside)

    // Sequencer: setup, strobe low, hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= nbi_pkg::NBI_IDLE;
            cnt_q <= 3'h0;
        end else if (st_q == nbi_pkg::NBI_IDLE) begin
            if (req_valid && req_ready) begin
                st_q  <= nbi_pkg::NBI_SETUP;
                cnt_q <= 3'h1;
            end
        end else if (cnt_q < phase_len(st_q)) begin
            cnt_q <= cnt_q + 3'h1;
        end else begin
            cnt_q <= 3'h1;
            unique case (st_q)
                nbi_pkg::NBI_SETUP:  st_q <= nbi_pkg::NBI_STROBE;
                nbi_pkg::NBI_STROBE: st_q <= nbi_pkg::NBI_HOLD;
                nbi_pkg::NBI_HOLD:   st_q <= nbi_pkg::NBI_IDLE;
                nbi_pkg::NBI_IDLE:   st_q <= nbi_pkg::NBI_IDLE;
            endcase
        end
    end

    // Request latch: kind, data, chip select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_q   <= nbi_pkg::NBI_OP_CMD;
            dout_q <= 8'h00;
            cs_q   <= 1'b0;
        end else if (st_q == nbi_pkg::NBI_IDLE && req_valid && req_ready) begin
            op_q   <= req_op;
            dout_q <= req_data; // (caller packs cycles)
            cs_q   <= 1'b1;
        end else if (st_q == nbi_pkg::NBI_IDLE && !req_valid) begin
            cs_q   <= 1'b0;     // Release chip select between bursts
        end
    end

    // Write protect follows the caller, low by default
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) write_prot_n <= 1'b0;
        else        write_prot_n <= wp_allow;
    end

    // Pin decode
    assign chip_sel_n     = !cs_q;
    assign cmd_latch      = (st_q != nbi_pkg::NBI_IDLE) && op_q == nbi_pkg::NBI_OP_CMD;
    assign addr_latch     = (st_q != nbi_pkg::NBI_IDLE) && op_q == nbi_pkg::NBI_OP_ADDR;
    // Write strobe rises at end of strobe phase, byte stable through hold
    assign write_strobe_n = !(st_q == nbi_pkg::NBI_STROBE
                              && op_q != nbi_pkg::NBI_OP_RD);
    // Read strobe low only for read cycles
    assign read_strobe_n  = !(st_q == nbi_pkg::NBI_STROBE
                              && op_q == nbi_pkg::NBI_OP_RD);
    assign io_o           = dout_q;
    // Drive bus only on write-type cycles, never while reading
    assign io_oe = (st_q != nbi_pkg::NBI_IDLE) && op_q != nbi_pkg::NBI_OP_RD;

    // Sample read byte on last strobe cycle
    assign cap_valid = st_q == nbi_pkg::NBI_STROBE && op_q == nbi_pkg::NBI_OP_RD
                       && cnt_q == `NBI_STROBE_CYC;
    assign cap_data  = io_i;

    // Device has latched a write-type byte in the last hold cycle
    assign byte_done = (st_q == nbi_pkg::NBI_HOLD) && (cnt_q == `NBI_HOLD_CYC)
                       && (op_q != nbi_pkg::NBI_OP_RD);

    // Address cycle count since the last command byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acyc_q <= 3'h0;
        end else if (byte_done && op_q == nbi_pkg::NBI_OP_CMD) begin
            acyc_q <= 3'h0;          // New command restarts the address cycles
        end else if (byte_done && op_q == nbi_pkg::NBI_OP_ADDR && acyc_q != 3'h7) begin
            acyc_q <= acyc_q + 3'h1; // Saturates, surplus bytes never wrap
        end
    end

    // Low column byte, kept to judge the whole column on the next cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            col_lo_q <= 8'h00;
        end else if (byte_done && op_q == nbi_pkg::NBI_OP_ADDR && acyc_q == 3'h0) begin
            col_lo_q <= dout_q;
        end
    end

    nbi_buf2 u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (cap_valid),
        .in_ready  (buf_ready),
        .in_data   (cap_data),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // Write strobe: low for the strobe phase, then back high
    sequence s_strobe;
        !write_strobe_n [*2] ##1 write_strobe_n;
    endsequence
    // Read strobe: capture on its last low cycle, then release
    sequence s_read_pulse;
        ##1 cap_valid ##1 read_strobe_n;
    endsequence

    chk_strobe_width: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(write_strobe_n) |-> s_strobe)
        else $error("write strobe width wrong");
    chk_latch_excl: assert property (@(posedge clk) disable iff (!rst_n)
        !(cmd_latch && addr_latch))
        else $error("both latches high");
    chk_cmd_stable: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(write_strobe_n) && cmd_latch |-> io_oe && $stable(io_o))
        else $error("cmd unstable");
    chk_read_nodrive: assert property (@(posedge clk) disable iff (!rst_n)
        !read_strobe_n |-> !io_oe)
        else $error("bus driven on read");
    chk_cs_active: assert property (@(posedge clk) disable iff (!rst_n)
        (!write_strobe_n || !read_strobe_n) |-> !chip_sel_n)
        else $error("strobe without cs");
    chk_read_capture: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(read_strobe_n) |-> s_read_pulse)
        else $error("read capture");
    chk_wp_follow: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 write_prot_n == $past(wp_allow))
        else $error("wp not following");
    chk_busy_map: assert property (@(posedge clk) disable iff (!rst_n)
        dev_busy != ready_busy_n)
        else $error("busy map");
    // Caller bytes are judged as the device latches them
    chk_cmd_known: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(write_strobe_n) && cmd_latch |-> cmd_known(io_o))
        else $error("undefined command code sent");
    chk_col_in_page: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(write_strobe_n) && addr_latch && acyc_q == 3'h1
        |-> {io_o[3:0], col_lo_q} < `NBI_PAGE_BYTES)
        else $error("column beyond page end");
    chk_addr_pad: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(write_strobe_n) && addr_latch |-> pad_low(acyc_q, io_o))
        else $error("unused address lines not low");
endmodule

// ==== logic/nbi_pkg.sv ====
package nbi_pkg;
    // Kind of bus cycle requested
    typedef enum logic [1:0] {
        NBI_OP_CMD  = 2'h0,
        NBI_OP_ADDR = 2'h1,
        NBI_OP_WR   = 2'h2,
        NBI_OP_RD   = 2'h3
    } nbi_op_t;
    // Pin sequencer states
    typedef enum logic [1:0] {
        NBI_IDLE   = 2'h0,
        NBI_SETUP  = 2'h1,
        NBI_STROBE = 2'h2,
        NBI_HOLD   = 2'h3
    } nbi_state_t;
endpackage

// ==== logic/nbi_regs.svh ====
// Contract
// - Address latch high marks address bytes
// - Command latch high marks command bytes
// - Column in cycles one and two
// - Row bits 12-28 in cycles three-five
// - Host drives unused address lines low
// - One shared 8-bit bus for all
// - Host issues only defined command codes
// - Random column commands stay within page
`ifndef NBI_REGS_SVH
`define NBI_REGS_SVH
// Strobe phase lengths in clock cycles (20 ns each)
`define NBI_SETUP_CYC   3'h2
`define NBI_STROBE_CYC  3'h2
`define NBI_HOLD_CYC    3'h1
// Geometry
`define NBI_PAGE_BYTES  12'h840
`define NBI_MAIN_BYTES  12'h800
`define NBI_BLOCKS      12'h800
`define NBI_PAGES       7'h40
// Address cycle field positions
`define NBI_ROW_LSB     12
`define NBI_PLANE_BIT   18
`endif

// ==== verification/nbi_dev_model.sv ====
`timescale 1ns/1ps
// Behavioural flash device on the far side of the host sequencer
module nbi_dev_model #(
    parameter time READ_ACCESS_DELAY = 15ns, // Output delay after read strobe fall
    parameter time BUSY_TIME         = 400ns // Length of an array operation
) (
    // Host pins
    input  wire logic       chip_sel_n,
    input  wire logic       cmd_latch,
    input  wire logic       addr_latch,
    input  wire logic       write_strobe_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_prot_n,
    input  wire logic [7:0] io_o,
    input  wire logic       io_oe,
    // Resolved bus and busy pull
    output logic [7:0]      io_i,
    output logic            busy_pull
);
    logic [7:0]  cmd_q  = 8'h00;  // Last command byte
    logic [2:0]  acnt_q = 3'h0;   // Address cycles seen
    logic [11:0] col_q  = 12'h000; // Column pointer
    logic [16:0] row_q  = 17'h0;  // Row address
    logic [7:0]  out_q  = 8'h00;  // Byte offered on reads
    logic        busy_q = 1'b0;   // Array operation in progress
    logic        drv;             // Device drives the bus
    logic        plane;           // Plane select
    logic [5:0]  page;            // Page in block
    logic [10:0] block;           // Block number
    assign plane = row_q[6];
    assign page  = row_q[5:0];
    assign block = row_q[16:6];
    // Drive only while reading; host byte while host drives, else inverse of last byte
    assign drv  = !chip_sel_n && !read_strobe_n && !cmd_latch && !addr_latch;
    assign io_i = io_oe ? io_o : (drv ? out_q : ~out_q);
    // Latch command and address bytes on write strobe rise
    always @(posedge write_strobe_n) begin
        if (!chip_sel_n && cmd_latch) begin
            cmd_q = io_i;
            acnt_q = 3'h0;
        end else if (!chip_sel_n && addr_latch && acnt_q < 3'h5) begin
            case (acnt_q)
                3'h0: col_q[7:0] = io_i;
                3'h1: col_q[11:8] = io_i[3:0];
                3'h2: row_q[7:0] = io_i;
                3'h3: row_q[15:8] = io_i;
                default: row_q[16] = io_i[0];
            endcase
            acnt_q = acnt_q + 3'h1;
        end
    end
    // Program and erase confirms (10h, D0h) start a busy period, only while protect is released
    always @(posedge write_strobe_n) begin
        if (!chip_sel_n && cmd_latch && write_prot_n && io_i inside {8'h10, 8'hD0}) begin
            busy_q = 1'b1;
            #BUSY_TIME;
            busy_q = 1'b0;
        end
    end
    assign busy_pull = busy_q;
    // Next byte after strobe fall, column advances per pulse
    always @(negedge read_strobe_n) if (!chip_sel_n) out_q <= #READ_ACCESS_DELAY col_q[7:0] ^ 8'h5A;
    always @(posedge read_strobe_n) if (!chip_sel_n) col_q = col_q + 12'h001;
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
// Host sequencer bench against the device model
module tb;
    logic       clk, rst_n, req_valid, req_ready, wp_allow, rd_valid, rd_ready, dev_busy;
    logic       cs_n, cle, ale, we_n, re_n, wp_n, io_oe, busy_pull, ready_busy_n;
    logic [7:0] req_data, rd_data, io_o, io_i;
    nbi_pkg::nbi_op_t req_op;
    int         fail_count = 0, cmp_count = 0, cyc = 0;
    assign ready_busy_n = busy_pull ? 1'b0 : 1'b1; // Pull-up unless pulled
    nbi_host u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_data(req_data), .wp_allow(wp_allow), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .dev_busy(dev_busy), .chip_sel_n(cs_n),
        .cmd_latch(cle), .addr_latch(ale), .write_strobe_n(we_n), .read_strobe_n(re_n),
        .write_prot_n(wp_n), .io_o(io_o), .io_oe(io_oe), .io_i(io_i),
        .ready_busy_n(ready_busy_n));
    nbi_dev_model u_dev (.chip_sel_n(cs_n), .cmd_latch(cle), .addr_latch(ale),
        .write_strobe_n(we_n), .read_strobe_n(re_n), .write_prot_n(wp_n), .io_o(io_o),
        .io_oe(io_oe), .io_i(io_i), .busy_pull(busy_pull));
    // Clock generator
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // Compare one value
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One request, held until taken
    task automatic send(input nbi_pkg::nbi_op_t op, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_data <= d;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk("req_ready", 17'h1, req_ready);
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    // Accept one read byte and compare it
    task automatic take(input logic [7:0] exp);
        int n = 0;
        @(posedge clk) rd_ready <= 1'b1;
        @(negedge clk);
        while (rd_valid !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk("rd_valid", 17'h1, rd_valid);
        chk("rd_data", exp, rd_data);
        @(posedge clk) rd_ready <= 1'b0;
    endtask
    // Wait up to n cycles for the busy flag to reach v
    task automatic wait_busy(input logic v, input int n);
        while (dev_busy !== v && n > 0) begin
            @(negedge clk);
            n--;
        end
        chk("dev_busy", v, dev_busy);
    endtask
    // Command then five address cycles and one surplus byte
    task automatic t_addr;
        send(nbi_pkg::NBI_OP_CMD, 8'h00);
        send(nbi_pkg::NBI_OP_ADDR, 8'h3D);
        send(nbi_pkg::NBI_OP_ADDR, 8'h08);
        send(nbi_pkg::NBI_OP_ADDR, 8'h45);
        send(nbi_pkg::NBI_OP_ADDR, 8'h23);
        send(nbi_pkg::NBI_OP_ADDR, 8'h01);
        send(nbi_pkg::NBI_OP_ADDR, 8'hFF);
        // Surplus byte is ignored by the device and chip select drops only after the hold phase
        repeat (8) @(negedge clk);
        chk("cmd", 17'h00, u_dev.cmd_q);
        chk("col", 17'h83D, u_dev.col_q);
        chk("row", 17'h12345, u_dev.row_q);
        chk("plane", 17'h1, u_dev.plane);
        chk("page", 17'h05, u_dev.page);
        chk("block", 17'h48D, u_dev.block);
        chk("chip_sel_n", 17'h1, cs_n);
    endtask
    // Fill read buffer while stalled, check refusal, then drain
    task automatic t_read;
        send(nbi_pkg::NBI_OP_RD, 8'h00);
        send(nbi_pkg::NBI_OP_RD, 8'h00);
        @(posedge clk) req_valid <= 1'b1;
        repeat (10) @(negedge clk);
        chk("req_ready full", 17'h0, req_ready);
        @(posedge clk) req_valid <= 1'b0;
        take(8'h67);
        take(8'h64);
        send(nbi_pkg::NBI_OP_RD, 8'h00);
        take(8'h65);
    endtask
    // Program confirm blocked by protect, then accepted
    task automatic t_wp;
        send(nbi_pkg::NBI_OP_CMD, 8'h80);
        send(nbi_pkg::NBI_OP_CMD, 8'h10);
        repeat (20) @(negedge clk);
        chk("dev_busy protected", 17'h0, dev_busy);
        @(posedge clk) wp_allow <= 1'b1;
        repeat (3) @(negedge clk);
        chk("write_prot_n", 17'h1, wp_n);
        send(nbi_pkg::NBI_OP_CMD, 8'h80);
        send(nbi_pkg::NBI_OP_CMD, 8'h10);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 50);
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_op = nbi_pkg::NBI_OP_CMD;
        req_data = 8'h00;
        wp_allow = 1'b0;
        rd_ready = 1'b0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk("reset pins", 17'hE0, {cs_n, we_n, re_n, cle, ale, io_oe, wp_n, rd_valid});
        @(posedge clk) rst_n <= 1'b1;
        t_addr();
        t_read();
        t_wp();
        stop_test();
    end
endmodule
